// >>> pkg/motion_readout_defines.svh
// Register indices, reset values and timing constants of the motion readout bank
`ifndef MOTION_READOUT_DEFINES_SVH
`define MOTION_READOUT_DEFINES_SVH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define IDX_SECOND_SENSOR_Z_HIGH 6'h0f
`define IDX_SECOND_SENSOR_R_LOW 6'h10
`define IDX_SECOND_SENSOR_R_HIGH 6'h11
`define IDX_ACCEL_X_LOW 6'h12
`define IDX_ACCEL_X_HIGH 6'h13
`define IDX_ACCEL_Y_LOW 6'h14
`define IDX_ACCEL_Y_HIGH 6'h15
`define IDX_ACCEL_Z_LOW 6'h16
`define IDX_ACCEL_Z_HIGH 6'h17
`define IDX_TIME_COUNTER_BYTE0 6'h18
`define IDX_TIME_COUNTER_BYTE1 6'h19
`define IDX_TIME_COUNTER_BYTE2 6'h1a
`define IDX_ACCEL_STATUS 6'h03

// ************************************************************
// Field positions and reset values
// ************************************************************
`define ACCEL_STATUS_READY_BIT 7
`define DATA_BYTE_RESET 8'h00
`define DATA_WORD_RESET 16'h0000
`define TIME_RESET 24'h000000

// ************************************************************
// Timing: all times in tenths of a nanosecond
// ************************************************************
`define REF_CLK_PERIOD_TENTHS_NS 50
`define TIME_LSB_TENTHS_NS 390625
`define TIME_BYTE1_WEIGHT_TENTHS_NS 100000000
`define TIME_BYTE2_WEIGHT_TENTHS_NS 25600000000

`endif

// >>> pkg/motion_readout_pkg.sv
// Types shared by the motion readout bank
package motion_readout_pkg;

    // One new acceleration sample from the sensor core
    typedef struct packed {
        logic valid;
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } accel_sample_t;

    // One new secondary sensor sample from the sensor core
    typedef struct packed {
        logic valid;
        logic [15:0] z;
        logic [15:0] r;
    } second_sample_t;

    // AHB-Lite request seen by the slave
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
    } ahb_req_t;

endpackage

// >>> hw/time_counter.sv
// Free-running 24-bit sensor time counter with a fractional tick divider
`timescale 1ns/1ps
`include "motion_readout_defines.svh"

module time_counter
    import motion_readout_pkg::*;
#(
    parameter int TICK_PERIOD = `TIME_LSB_TENTHS_NS,
    parameter int CLK_PERIOD = `REF_CLK_PERIOD_TENTHS_NS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    output logic [23:0] timeValue
);

    // The tick is 7812.5 clocks, so a phase accumulator alternates 7812 and 7813
    // cycles; this keeps long-term drift at zero instead of rounding the period.
    localparam logic [19:0] TickStep = 20'(CLK_PERIOD);
    localparam logic [19:0] TickPeriod = 20'(TICK_PERIOD);

    logic [19:0] phase_reg; // Elapsed time since last tick
    logic [19:0] phase_next; // Phase after this cycle
    logic [23:0] count_reg; // Sensor time
    logic tickDue; // One-cycle enable: a time unit has passed

    assign phase_next = phase_reg + TickStep;
    assign tickDue = (phase_next >= TickPeriod);
    assign timeValue = count_reg;

    // ************************************************************
    // Divider and counter
    // ************************************************************
    // Counter wraps naturally from all ones to zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase_reg <= 20'h00000;
            count_reg <= `TIME_RESET;
        end else if (tickDue) begin
            phase_reg <= phase_next - TickPeriod;
            count_reg <= count_reg + 24'h000001;
        end else begin
            phase_reg <= phase_next;
        end
    end

endmodule

// >>> hw/motion_data_time_readout.sv
// Read-only motion data and sensor time register bank behind an AHB-Lite slave
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "motion_readout_defines.svh"

// What this block does
// - Secondary Z high byte at 0x0F
// - Secondary R low 0x10, high 0x11
// - Accel X low 0x12, high 0x13
// - Accel Y low 0x14, high 0x15
// - Accel Z low 0x16, high 0x17
// - Time byte 0 at 0x18, 39.0625 us
// - Time byte 1 at 0x19, 10 ms
// - All bytes read-only, zero after reset
// - Time byte 2 at 0x1A, 2.56 s
// - Reading accel byte clears data-ready flag
module motion_data_time_readout
    import motion_readout_pkg::*;
#(
    parameter int TICK_PERIOD = `TIME_LSB_TENTHS_NS,
    parameter int CLK_PERIOD = `REF_CLK_PERIOD_TENTHS_NS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire accel_sample_t accelIn,
    input wire second_sample_t secondIn,
    output logic accelDataReady
);

    // ************************************************************
    // Bus request decode
    // ************************************************************
    ahb_req_t req; // Address phase signals grouped
    logic [5:0] regIndex; // Word index of the addressed register
    logic addrInRange; // Address lies in the decoded window
    logic transferTaken; // Address phase accepted this edge
    logic readTaken; // A read is accepted this edge
    logic accelByteRead; // The read hits any acceleration byte

    // One driver for the whole struct; fields in declaration order
    assign req = {hsel, haddr, htrans, hwrite, hsize, hready};

    // Only bits 7:2 carry the index; anything above is unmapped
    assign regIndex = req.haddr[7:2];
    assign addrInRange = (req.haddr[31:8] == 24'h000000);
    // NONSEQ and SEQ both start a transfer; IDLE and BUSY are ignored
    assign transferTaken = req.hsel && req.htrans[1] && req.hready;
    // Writes are accepted with OKAY and dropped, so every byte stays read-only
    assign readTaken = transferTaken && !req.hwrite && addrInRange;
    assign accelByteRead = readTaken
        && (regIndex >= `IDX_ACCEL_X_LOW)
        && (regIndex <= `IDX_ACCEL_Z_HIGH);

    // ************************************************************
    // Live sample registers
    // ************************************************************
    logic [15:0] secondZ_reg; // Latest secondary Z value
    logic [15:0] secondR_reg; // Latest secondary R value
    logic [15:0] accelX_reg; // Latest X acceleration
    logic [15:0] accelY_reg; // Latest Y acceleration
    logic [15:0] accelZ_reg; // Latest Z acceleration

    // Secondary sensor sample capture
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            secondZ_reg <= `DATA_WORD_RESET;
            secondR_reg <= `DATA_WORD_RESET;
        end else if (secondIn.valid) begin
            secondZ_reg <= secondIn.z;
            secondR_reg <= secondIn.r;
        end
    end

    // Acceleration sample capture
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            accelX_reg <= `DATA_WORD_RESET;
            accelY_reg <= `DATA_WORD_RESET;
            accelZ_reg <= `DATA_WORD_RESET;
        end else if (accelIn.valid) begin
            accelX_reg <= accelIn.x;
            accelY_reg <= accelIn.y;
            accelZ_reg <= accelIn.z;
        end
    end

    // ************************************************************
    // Sensor time
    // ************************************************************
    logic [23:0] timeValue; // Running 24-bit sensor time

    time_counter #(
        .TICK_PERIOD(TICK_PERIOD),
        .CLK_PERIOD(CLK_PERIOD)
    ) timeCounter (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .timeValue(timeValue)
    );

    // ************************************************************
    // Coherent shadows
    // ************************************************************
    // Reading the lowest byte of a group freezes the rest of that group, so the
    // higher bytes read afterwards come from the same sample or time value.
    // Limitation: a higher byte read without first reading the low byte
    // returns whatever was frozen last.
    logic readRLow; // Low byte of secondary R read
    logic readAccelLow; // Lowest acceleration byte read
    logic readTimeLow; // Lowest time byte read
    logic [7:0] secondRHighShadow_reg; // Frozen R high byte
    logic [7:0] accelXHighShadow_reg; // Frozen X high byte
    logic [15:0] accelYShadow_reg; // Frozen Y value
    logic [15:0] accelZShadow_reg; // Frozen Z value
    logic [15:0] timeShadow_reg; // Frozen time bytes 1 and 2

    assign readRLow = readTaken && (regIndex == `IDX_SECOND_SENSOR_R_LOW);
    assign readAccelLow = readTaken && (regIndex == `IDX_ACCEL_X_LOW);
    assign readTimeLow = readTaken && (regIndex == `IDX_TIME_COUNTER_BYTE0);

    // Secondary R shadow
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            secondRHighShadow_reg <= `DATA_BYTE_RESET;
        end else if (readRLow) begin
            secondRHighShadow_reg <= secondR_reg[15:8];
        end
    end

    // Acceleration shadow, taken from the live set the low byte comes from
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            accelXHighShadow_reg <= `DATA_BYTE_RESET;
            accelYShadow_reg <= `DATA_WORD_RESET;
            accelZShadow_reg <= `DATA_WORD_RESET;
        end else if (readAccelLow) begin
            accelXHighShadow_reg <= accelX_reg[15:8];
            accelYShadow_reg <= accelY_reg;
            accelZShadow_reg <= accelZ_reg;
        end
    end

    // Time shadow; a carry between the low and high reads cannot tear the value
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            timeShadow_reg <= `DATA_WORD_RESET;
        end else if (readTimeLow) begin
            timeShadow_reg <= timeValue[23:8];
        end
    end

    // ************************************************************
    // Acceleration data-ready flag
    // ************************************************************
    logic accelReady_reg; // Set by a new sample, cleared by an accel read
    logic accelReady_next; // Next flag value

    // A sample arriving in the clearing cycle wins so it is never lost
    assign accelReady_next = accelIn.valid ? 1'b1
        : (accelByteRead ? 1'b0 : accelReady_reg);

    // Flag register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            accelReady_reg <= 1'b0;
        end else begin
            accelReady_reg <= accelReady_next;
        end
    end

    // ************************************************************
    // Read data selection
    // ************************************************************
    logic [7:0] readByte; // Byte at the addressed register
    logic [7:0] statusByte; // Status register image

    assign statusByte = {accelReady_reg, 7'h00};

    // Unmapped indices and reserved bits read as zero
    assign readByte =
        (regIndex == `IDX_SECOND_SENSOR_Z_HIGH) ? secondZ_reg[15:8] :
        (regIndex == `IDX_SECOND_SENSOR_R_LOW) ? secondR_reg[7:0] :
        (regIndex == `IDX_SECOND_SENSOR_R_HIGH) ? secondRHighShadow_reg :
        (regIndex == `IDX_ACCEL_X_LOW) ? accelX_reg[7:0] :
        (regIndex == `IDX_ACCEL_X_HIGH) ? accelXHighShadow_reg :
        (regIndex == `IDX_ACCEL_Y_LOW) ? accelYShadow_reg[7:0] :
        (regIndex == `IDX_ACCEL_Y_HIGH) ? accelYShadow_reg[15:8] :
        (regIndex == `IDX_ACCEL_Z_LOW) ? accelZShadow_reg[7:0] :
        (regIndex == `IDX_ACCEL_Z_HIGH) ? accelZShadow_reg[15:8] :
        (regIndex == `IDX_TIME_COUNTER_BYTE0) ? timeValue[7:0] :
        (regIndex == `IDX_TIME_COUNTER_BYTE1) ? timeShadow_reg[7:0] :
        (regIndex == `IDX_TIME_COUNTER_BYTE2) ? timeShadow_reg[15:8] :
        (regIndex == `IDX_ACCEL_STATUS) ? statusByte :
        `DATA_BYTE_RESET;

    // ************************************************************
    // AHB-Lite response
    // ************************************************************
    // Zero wait states: data is registered at the address-phase edge and
    // stands through the data phase. hwdata is never used since nothing
    // in the bank can be written.
    logic [31:0] hrdata_reg; // Registered read data
    logic hreadyout_reg; // Always ready, held high through reset
    logic hresp_reg; // Always OKAY

    // Read data register; holds until the next accepted transfer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hrdata_reg <= 32'h00000000;
        end else if (readTaken) begin
            hrdata_reg <= {24'h000000, readByte};
        end else if (transferTaken) begin
            // Writes and unmapped reads return zero
            hrdata_reg <= 32'h00000000;
        end
    end

    // Handshake registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end else begin
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = hresp_reg;
    assign accelDataReady = accelReady_reg;

endmodule

// >>> testbench/motion_data_time_readout_assertions.sv
// Port-level checker for the motion readout bank, bound into the design
`timescale 1ns/1ps

module motion_data_time_readout_assertions
    import motion_readout_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire accel_sample_t accelIn,
    input wire logic accelDataReady
);
    // ************************************************************
    // Decoded bus events
    // ************************************************************
    wire taken = hsel && htrans[1] && hready; // Address phase accepted
    wire inRange = haddr[31:8] == 24'h0; // Upper address bits clear
    // Any accel data byte, indices 0x12 to 0x17
    wire accelRd = taken && !hwrite && inRange && haddr[7:2] >= 6'h12 && haddr[7:2] <= 6'h17;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // ************************************************************
    // Properties
    // ************************************************************
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("hreadyout low");
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("hresp not OKAY");
    property p_upper; hrdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("hrdata upper bits set");
    property p_wr; taken && hwrite |=> hrdata == 32'h0; endproperty
    a_wr: assert property (p_wr) else $error("write gave data");
    property p_unmap; taken && !hwrite && !inRange |=> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read gave data");
    // Read data only moves when a transfer is taken
    property p_hold; !taken |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("hrdata moved without transfer");
    property p_set; accelIn.valid |=> accelDataReady; endproperty
    a_set: assert property (p_set) else $error("ready flag not set");
    property p_clr; accelRd && !accelIn.valid |=> !accelDataReady; endproperty
    a_clr: assert property (p_clr) else $error("ready flag not cleared");
    property p_keep; !accelRd && !accelIn.valid |=> $stable(accelDataReady); endproperty
    a_keep: assert property (p_keep) else $error("ready flag moved");
    // Reset must be checked while reset is high, so this one is never disabled
    property p_rst; disable iff (1'b0) sys_rst |=> hrdata == 32'h0 && !accelDataReady; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule

bind motion_data_time_readout motion_data_time_readout_assertions checker_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .accelIn(accelIn), .accelDataReady(accelDataReady)
);

// >>> testbench/host_bus_model.sv
// AHB-Lite host model that issues single word transfers to the bank
`timescale 1ns/1ps

module host_bus_model (
    input wire logic ref_clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // Idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // ************************************************************
    // One transfer: address phase, then data phase, each held until hready
    // ************************************************************
    task automatic busXfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                           output logic [31:0] rdata, output bit ok);
        int n;
        ok = 1'b0;
        rdata = 32'h0;
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= 2'b10;
        hwrite <= wr;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge ref_clk);
            ok = (hready === 1'b1);
        end
        if (!ok) return;
        // Address no longer qualified, so it is scrambled rather than left stale
        htrans <= 2'b00;
        haddr <= ~addr;
        hwdata <= wdata;
        ok = 1'b0;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge ref_clk);
            ok = (hready === 1'b1);
        end
        rdata = hrdata;
        hwdata <= ~wdata;
    endtask
endmodule

// >>> testbench/motion_data_time_readout_bench.sv
// Self-checking bench for the motion readout bank
`timescale 1ns/1ps
`include "motion_readout_defines.svh"

module motion_data_time_readout_bench;
    import motion_readout_pkg::*;
    localparam int TICK = 200; // One time count every 4 cycles
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    wire logic hsel, hwrite, hready, hreadyout, hresp, accelDataReady;
    wire logic [31:0] haddr, hwdata, hrdata;
    wire logic [1:0] htrans;
    wire logic [2:0] hsize;
    accel_sample_t accelIn = '0;
    second_sample_t secondIn = '0;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;

    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= sys_rst ? 0 : cyc + 1;
    assign hready = hreadyout; // Single slave drives the bus ready

    motion_data_time_readout #(.TICK_PERIOD(TICK), .CLK_PERIOD(50))
        motion_data_time_readout_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .accelIn(accelIn), .secondIn(secondIn), .accelDataReady(accelDataReady));
    host_bus_model host_bus_model_inst (.ref_clk(ref_clk), .hready(hready), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));

    // ************************************************************
    // Shared helpers
    // ************************************************************
    task automatic summarize;
        $display("Checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Any bus access; a hung bus ends the run
    task automatic xfer(input logic wr, input logic [31:0] a, output logic [31:0] d);
        bit ok;
        host_bus_model_inst.busXfer(wr, a, 32'h5a5a5a5a, d, ok);
        if (!ok) begin
            num_errors++;
            $display("MISMATCH t=%0t bus timeout", $time);
            summarize();
        end
    endtask
    task automatic rdChk(input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        xfer(1'b0, {24'h0, idx, 2'b00}, d);
        check(d, exp, $sformatf("index %h", idx));
    endtask
    task automatic pulse(input logic [15:0] x, y, z, input logic [15:0] sz, sr);
        @(posedge ref_clk);
        accelIn <= {1'b1, x, y, z};
        secondIn <= {1'b1, sz, sr};
        @(posedge ref_clk);
        accelIn.valid <= 1'b0;
        secondIn.valid <= 1'b0;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic resetValues;
        for (int i = 'h0f; i <= 'h17; i++) rdChk(i[5:0], 32'h0);
        rdChk(`IDX_TIME_COUNTER_BYTE1, 32'h0);
        rdChk(`IDX_ACCEL_STATUS, 32'h0);
    endtask
    task automatic dataMap;
        pulse(16'h1234, 16'h5678, 16'h9abc, 16'ha5c3, 16'h9e71);
        // The flag rises at the edge pulse returns on; look once it has settled
        @(negedge ref_clk);
        check(accelDataReady, 1'b1, "flag set");
        rdChk(`IDX_ACCEL_STATUS, 32'h80);
        rdChk(`IDX_SECOND_SENSOR_Z_HIGH, 32'ha5);
        rdChk(`IDX_SECOND_SENSOR_R_LOW, 32'h71);
        rdChk(`IDX_SECOND_SENSOR_R_HIGH, 32'h9e);
        rdChk(`IDX_ACCEL_X_LOW, 32'h34);
        check(accelDataReady, 1'b0, "flag clear");
        rdChk(`IDX_ACCEL_X_HIGH, 32'h12);
        rdChk(`IDX_ACCEL_Y_LOW, 32'h78);
        rdChk(`IDX_ACCEL_Y_HIGH, 32'h56);
        rdChk(`IDX_ACCEL_Z_LOW, 32'hbc);
        rdChk(`IDX_ACCEL_Z_HIGH, 32'h9a);
        rdChk(`IDX_ACCEL_STATUS, 32'h0);
    endtask
    // Writes and unmapped places give zero and change nothing
    task automatic refused;
        logic [31:0] d;
        xfer(1'b1, 32'h48, d);
        check(d, 32'h0, "write data");
        rdChk(`IDX_ACCEL_X_LOW, 32'h34);
        xfer(1'b0, 32'h100, d);
        check(d, 32'h0, "unmapped high");
        rdChk(6'h01, 32'h0);
    endtask
    // A new sample between low and high reads must not tear the value
    task automatic coherence;
        rdChk(`IDX_ACCEL_X_LOW, 32'h34);
        rdChk(`IDX_SECOND_SENSOR_R_LOW, 32'h71);
        pulse(16'h4321, 16'h8765, 16'hcba9, 16'h0f00, 16'h2468);
        rdChk(`IDX_ACCEL_X_HIGH, 32'h12);
        rdChk(`IDX_ACCEL_Z_HIGH, 32'h9a);
        rdChk(`IDX_SECOND_SENSOR_R_HIGH, 32'h9e);
        rdChk(`IDX_SECOND_SENSOR_Z_HIGH, 32'h0f);
        rdChk(`IDX_ACCEL_X_LOW, 32'h21);
        rdChk(`IDX_ACCEL_Y_HIGH, 32'h87);
    endtask
    // Time bytes read in order form one count near cycles since reset over four
    task automatic timeCount;
        logic [31:0] b0, b1, b2;
        int c, t;
        repeat (1200) @(posedge ref_clk);
        c = cyc;
        xfer(1'b0, {24'h0, `IDX_TIME_COUNTER_BYTE0, 2'b00}, b0);
        xfer(1'b0, {24'h0, `IDX_TIME_COUNTER_BYTE1, 2'b00}, b1);
        xfer(1'b0, {24'h0, `IDX_TIME_COUNTER_BYTE2, 2'b00}, b2);
        t = {b2[7:0], b1[7:0], b0[7:0]};
        tests_run++;
        if (t < c / 4 - 2 || t > c / 4 + 2) begin
            num_errors++;
            $display("MISMATCH t=%0t time %0d near %0d", $time, t, c / 4);
        end
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        resetValues();
        dataMap();
        refused();
        coherence();
        timeCount();
        summarize();
    end
endmodule
